// file: design/postproc_pkg.sv
// Shared widths, scale factors, modes and record layouts for the
// interval sample post-processor.
// Assumes one processing clock; samples arrive as whole records.
package postproc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int TIME_W = 24;
  localparam int INTERP_W = 6;
  localparam int EVENT_W = 24;
  localparam int CT_W = 32;
  localparam int EV_CW = 32;
  localparam int STAMP_W = 40;
  localparam int RES_W = 64;
  localparam int CNT_W = 7;
  localparam int FIFO_DEPTH = 4;

  // ----------------------------------------------------------------
  // Time scales, stamps are in units of STAMP_LSB_PS
  // ----------------------------------------------------------------
  localparam int TIME_LSB_PS = 2000;
  localparam int INTERP_LSB_PS = 100;
  localparam int STAMP_LSB_PS = 100;
  localparam logic [STAMP_W-1:0] TIME_SCALE =
    STAMP_W'(TIME_LSB_PS / STAMP_LSB_PS);
  localparam logic [STAMP_W-1:0] INTERP_SCALE =
    STAMP_W'(INTERP_LSB_PS / STAMP_LSB_PS);

  // ----------------------------------------------------------------
  // Event scaling and divider
  // ----------------------------------------------------------------
  localparam int CHAN_C_SHIFT = 2;  // Divided channel sees one in four
  localparam int FREQ_FRAC = 24;    // Fraction bits of a rate result
  localparam logic [CNT_W-1:0] DIV_STEPS = CNT_W'(RES_W);

  typedef enum logic [1:0] {
    MODE_INTERVAL = 2'h0,
    MODE_RATE = 2'h1,
    MODE_PERIOD = 2'h2
  } mode_t;

  // One record from the counter hardware
  typedef struct packed {
    logic block_start;
    logic inhibit;
    logic [EVENT_W-1:0] event_cnt;
    logic [TIME_W-1:0] time_cnt;
    logic [INTERP_W-1:0] interp;
  } sample_t;

  localparam int SAMPLE_W = $bits(sample_t);

  // Constants loaded before a block is processed
  typedef struct packed {
    logic [CT_W-1:0] time_wrap;
    logic [CT_W-1:0] pos_max;
    logic [CT_W-1:0] neg_max;
    logic [EV_CW-1:0] event_wrap;
    logic signed [STAMP_W-1:0] offset;
    mode_t mode;
    logic chan_c;
  } cfg_t;

  typedef struct packed {
    logic signed [RES_W-1:0] value;
    logic [RES_W-1:0] aux;
    logic block_start;
    logic inhibit;
    logic div_zero;
  } result_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_GET_START = 3'h1,
    ST_GET_STOP = 3'h3,
    ST_FIX_IN = 3'h2,
    ST_FIX_OUT = 3'h6,
    ST_STAMP = 3'h7,
    ST_DIVIDE = 3'h5,
    ST_EMIT = 3'h4
  } state_t;

endpackage : postproc_pkg

// file: design/sample_buffer.sv
// Small first-in first-out buffer built from flip-flops.
// Assumes both sides run on clock_i; ready on the fill side is registered.
`timescale 1ns/100ps
module sample_buffer #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);

  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PTR_W-1:0] wr;
    logic [PTR_W-1:0] rd;
    logic [CNT_W-1:0] count;
    logic in_ready;
  } buf_t;

  buf_t s_r, s_nxt;
  logic push, pop;

  assign push = in_valid_i && s_r.in_ready;
  assign pop = (s_r.count != '0) && out_ready_i;

  // Pointer, storage and fill level update
  always_comb begin
    s_nxt = s_r;
    if (push) begin
      s_nxt.mem[s_r.wr] = in_data_i;
      s_nxt.wr = (s_r.wr == LAST) ? '0 : s_r.wr + 1'b1;
    end
    if (pop) begin
      s_nxt.rd = (s_r.rd == LAST) ? '0 : s_r.rd + 1'b1;
    end
    if (push && !pop) begin
      s_nxt.count = s_r.count + 1'b1;
    end else if (pop && !push) begin
      s_nxt.count = s_r.count - 1'b1;
    end
    s_nxt.in_ready = (s_nxt.count != FULL);
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign in_ready_o = s_r.in_ready;
  assign out_valid_o = (s_r.count != '0);
  assign out_data_o = s_r.mem[s_r.rd];

endmodule : sample_buffer

// file: design/interval_sample_postprocessor.sv
// Turns start/stop sample records into corrected stamps and results.
// Assumes samples come from logic on clock_i and cfg is stable on load.
`timescale 1ns/100ps
module interval_sample_postprocessor (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic cfg_load_i,
  input wire postproc_pkg::cfg_t cfg_i,
  input wire logic sample_valid_i,
  input wire postproc_pkg::sample_t sample_i,
  output logic sample_ready_o,
  output logic result_valid_o,
  output postproc_pkg::result_t result_o,
  input wire logic result_ready_i
);
  import postproc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    state_t fsm;
    cfg_t cfg;
    sample_t a;
    sample_t b;
    logic [CT_W-1:0] ts;
    logic [CT_W-1:0] tp;
    logic [CT_W-1:0] acc;
    logic [CT_W-1:0] prev_max;
    logic [EV_CW-1:0] ea;
    logic [EV_CW-1:0] eb;
    logic [EV_CW-1:0] ev_acc;
    logic [EV_CW-1:0] prev_ev;
    logic [EV_CW-1:0] prev_stop;
    logic first;
    logic [RES_W-1:0] num;
    logic [RES_W-1:0] den;
    logic [RES_W-1:0] rem;
    logic [RES_W-1:0] quo;
    logic [RES_W-1:0] n0;
    logic [CNT_W-1:0] cnt;
    result_t res;
    logic res_valid;
  } st_t;

  st_t s_r, s_nxt;

  function automatic logic signed [STAMP_W-1:0] stamp_of(
    input logic [CT_W-1:0] ct,
    input logic [INTERP_W-1:0] ip
  );
    stamp_of = $signed(STAMP_W'(ct) * TIME_SCALE -
                       STAMP_W'(ip) * INTERP_SCALE);
  endfunction : stamp_of

  // ----------------------------------------------------------------
  // Input buffer
  // ----------------------------------------------------------------
  sample_t fifo_data;
  logic fifo_valid, fetch, take;

  sample_buffer #(.WIDTH(SAMPLE_W), .DEPTH(FIFO_DEPTH)) i_sample_buffer (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .in_valid_i(sample_valid_i),
    .in_data_i(sample_i),
    .in_ready_o(sample_ready_o),
    .out_valid_o(fifo_valid),
    .out_data_o(fifo_data),
    .out_ready_i(fetch)
  );

  // Records are only drawn while waiting for start or stop
  assign fetch = (s_r.fsm == ST_GET_START || s_r.fsm == ST_GET_STOP) &&
                 !cfg_load_i;
  assign take = fetch && fifo_valid;

  // ----------------------------------------------------------------
  // Datapath helpers
  // ----------------------------------------------------------------
  logic [EV_CW-1:0] ev_raw, ev_adj, ea_s, eb_s, ed;
  logic ev_rolled, hi, lo, wrap2, dz, ge;
  logic [CT_W-1:0] ts_raw, tp_raw, mn, mx;
  logic signed [CT_W:0] diff;
  logic signed [STAMP_W-1:0] sa, sb, el;
  logic [RES_W:0] r2;
  logic [RES_W-1:0] rem_n, qn;

  // Event rollover: any count below its predecessor wrapped
  assign ev_raw = EV_CW'(fifo_data.event_cnt) + s_r.ev_acc;
  assign ev_rolled = !(s_r.first && s_r.fsm == ST_GET_START) &&
                     (ev_raw < s_r.prev_ev);
  assign ev_adj = ev_rolled ? ev_raw + s_r.cfg.event_wrap : ev_raw;

  // Rollover between start and stop, judged against both limits
  assign ts_raw = CT_W'(s_r.a.time_cnt) + s_r.acc;
  assign tp_raw = CT_W'(s_r.b.time_cnt) + s_r.acc;
  assign diff = $signed({1'b0, tp_raw}) - $signed({1'b0, ts_raw});
  assign hi = diff > $signed({1'b0, s_r.cfg.pos_max});
  assign lo = diff < -$signed({1'b0, s_r.cfg.neg_max});

  // Rollover between pairs: later stamp of the last pair against earlier stamp of this pair
  assign mn = (s_r.ts < s_r.tp) ? s_r.ts : s_r.tp;
  assign mx = (s_r.ts > s_r.tp) ? s_r.ts : s_r.tp;
  assign wrap2 = !s_r.first && (s_r.prev_max > mn);

  // Stamps, intervals and scaled event counts
  assign ea_s = s_r.cfg.chan_c ? s_r.ea << CHAN_C_SHIFT : s_r.ea;
  assign eb_s = s_r.cfg.chan_c ? s_r.eb << CHAN_C_SHIFT : s_r.eb;
  assign ed = eb_s - ea_s;
  assign sa = stamp_of(s_r.ts, s_r.a.interp);
  assign sb = stamp_of(s_r.tp, s_r.b.interp) + s_r.cfg.offset;
  assign el = sb - sa;
  assign dz = (el <= 0) || (s_r.cfg.mode == MODE_PERIOD && ed == '0);

  // One restoring divider step per cycle
  assign r2 = {s_r.rem, s_r.num[RES_W-1]};
  assign ge = r2 >= {1'b0, s_r.den};
  assign rem_n = ge ? RES_W'(r2 - {1'b0, s_r.den}) : r2[RES_W-1:0];
  assign qn = {s_r.quo[RES_W-2:0], ge};

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (take) begin
      s_nxt.prev_ev = ev_adj;
      if (ev_rolled) begin
        s_nxt.ev_acc = s_r.ev_acc + s_r.cfg.event_wrap;
      end
    end
    case (s_r.fsm)
      ST_IDLE: begin
        s_nxt.fsm = ST_IDLE;
      end
      ST_GET_START: begin
        if (take) begin
          s_nxt.a = fifo_data;
          s_nxt.ea = ev_adj;
          s_nxt.fsm = ST_GET_STOP;
        end
      end
      ST_GET_STOP: begin
        if (take) begin
          s_nxt.b = fifo_data;
          s_nxt.eb = ev_adj;
          s_nxt.fsm = ST_FIX_IN;
        end
      end
      ST_FIX_IN: begin
        s_nxt.ts = ts_raw;
        s_nxt.tp = tp_raw;
        if (hi) begin
          s_nxt.ts = ts_raw + s_r.cfg.time_wrap;
          s_nxt.acc = s_r.acc + s_r.cfg.time_wrap;
        end else if (lo) begin
          s_nxt.tp = tp_raw + s_r.cfg.time_wrap;
          s_nxt.acc = s_r.acc + s_r.cfg.time_wrap;
        end
        s_nxt.fsm = ST_FIX_OUT;
      end
      ST_FIX_OUT: begin
        s_nxt.prev_max = mx;
        if (wrap2) begin
          s_nxt.ts = s_r.ts + s_r.cfg.time_wrap;
          s_nxt.tp = s_r.tp + s_r.cfg.time_wrap;
          s_nxt.acc = s_r.acc + s_r.cfg.time_wrap;
          s_nxt.prev_max = mx + s_r.cfg.time_wrap;
        end
        s_nxt.fsm = ST_STAMP;
      end
      ST_STAMP: begin
        s_nxt.first = 1'b0;
        s_nxt.prev_stop = eb_s;
        s_nxt.res.block_start = s_r.a.block_start;
        s_nxt.res.inhibit = s_r.a.inhibit | s_r.b.inhibit;
        s_nxt.res.div_zero = 1'b0;
        if (s_r.cfg.mode == MODE_INTERVAL) begin
          s_nxt.res.value = RES_W'(el);
          s_nxt.res.aux = s_r.first ? '0 :
                          RES_W'(ea_s - s_r.prev_stop - 1'b1);
          s_nxt.res_valid = 1'b1;
          s_nxt.fsm = ST_EMIT;
        end else begin
          s_nxt.res.aux = RES_W'(el);
          s_nxt.num = (s_r.cfg.mode == MODE_RATE) ?
                      RES_W'(ed) << FREQ_FRAC : RES_W'(el);
          s_nxt.den = (s_r.cfg.mode == MODE_RATE) ?
                      RES_W'(el) : RES_W'(ed);
          s_nxt.n0 = s_nxt.num;
          s_nxt.rem = '0;
          s_nxt.quo = '0;
          s_nxt.cnt = DIV_STEPS;
          if (dz) begin
            s_nxt.res.value = '1;
            s_nxt.res.div_zero = 1'b1;
            s_nxt.res_valid = 1'b1;
            s_nxt.fsm = ST_EMIT;
          end else begin
            s_nxt.fsm = ST_DIVIDE;
          end
        end
      end
      ST_DIVIDE: begin
        s_nxt.rem = rem_n;
        s_nxt.quo = qn;
        s_nxt.num = s_r.num << 1;
        s_nxt.cnt = s_r.cnt - 1'b1;
        if (s_r.cnt == CNT_W'(1)) begin
          s_nxt.res.value = qn;
          s_nxt.res_valid = 1'b1;
          s_nxt.fsm = ST_EMIT;
        end
      end
      ST_EMIT: begin
        if (result_ready_i) begin
          s_nxt.res_valid = 1'b0;
          s_nxt.fsm = ST_GET_START;
        end
      end
      default: begin
        s_nxt.fsm = ST_IDLE;
      end
    endcase
    // Loading constants restarts the scan and drops any pending result
    if (cfg_load_i) begin
      s_nxt.cfg = cfg_i;
      s_nxt.acc = '0;
      s_nxt.ev_acc = '0;
      s_nxt.prev_ev = '0;
      s_nxt.first = 1'b1;
      s_nxt.res_valid = 1'b0;
      s_nxt.fsm = ST_GET_START;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign result_valid_o = s_r.res_valid;
  assign result_o = s_r.res;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_pair_result;
    @(posedge clock_i) disable iff (reset_i || cfg_load_i)
    (take && s_r.fsm == ST_GET_STOP) |-> ##[4:68] s_r.res_valid;
  endproperty
  a_pair_result: assert property (p_pair_result)
    else $error("no result after a stop record");

  property p_in_range;
    @(posedge clock_i) disable iff (reset_i || cfg_load_i)
    (s_r.fsm == ST_FIX_IN && !hi && !lo) |=> s_r.acc == $past(s_r.acc);
  endproperty
  a_in_range: assert property (p_in_range)
    else $error("wrap applied to an in-range pair");

  property p_pass1_hi;
    @(posedge clock_i) disable iff (reset_i || cfg_load_i)
    (s_r.fsm == ST_FIX_IN && hi) |=>
      s_r.acc == $past(s_r.acc) + s_r.cfg.time_wrap &&
      s_r.tp == $past(tp_raw);
  endproperty
  a_pass1_hi: assert property (p_pass1_hi)
    else $error("high out-of-range pair not corrected on start");

  property p_pass1_lo;
    @(posedge clock_i) disable iff (reset_i || cfg_load_i)
    (s_r.fsm == ST_FIX_IN && lo) |=>
      s_r.acc == $past(s_r.acc) + s_r.cfg.time_wrap &&
      s_r.ts == $past(ts_raw);
  endproperty
  a_pass1_lo: assert property (p_pass1_lo)
    else $error("low out-of-range pair not corrected on stop");

  property p_pass2;
    @(posedge clock_i) disable iff (reset_i || cfg_load_i)
    (s_r.fsm == ST_FIX_OUT && wrap2) |=>
      s_r.ts == $past(s_r.ts) + s_r.cfg.time_wrap &&
      s_r.tp == $past(s_r.tp) + s_r.cfg.time_wrap &&
      s_r.acc == $past(s_r.acc) + s_r.cfg.time_wrap;
  endproperty
  a_pass2: assert property (p_pass2)
    else $error("rollover between pairs not corrected");

  property p_interval;
    @(posedge clock_i) disable iff (reset_i || cfg_load_i)
    (s_r.fsm == ST_EMIT && s_r.cfg.mode == MODE_INTERVAL) |->
      s_r.res.value == RES_W'((RES_W'(s_r.tp) - RES_W'(s_r.ts)) *
      RES_W'(TIME_SCALE) - RES_W'(s_r.b.interp) + RES_W'(s_r.a.interp) +
      RES_W'(s_r.cfg.offset));
  endproperty
  a_interval: assert property (p_interval)
    else $error("interval result does not match stamps");

  property p_quotient;
    @(posedge clock_i) disable iff (reset_i || cfg_load_i)
    (s_r.fsm == ST_EMIT && s_r.cfg.mode != MODE_INTERVAL &&
     !s_r.res.div_zero) |->
      (2*RES_W)'(s_r.quo) * (2*RES_W)'(s_r.den) + (2*RES_W)'(s_r.rem) ==
      (2*RES_W)'(s_r.n0) && s_r.rem < s_r.den;
  endproperty
  a_quotient: assert property (p_quotient)
    else $error("divider result inconsistent");

  property p_gate;
    @(posedge clock_i) disable iff (reset_i || cfg_load_i)
    (s_r.fsm == ST_STAMP && s_r.cfg.mode != MODE_INTERVAL) |=>
      s_r.res.aux == RES_W'($past(el));
  endproperty
  a_gate: assert property (p_gate)
    else $error("gate time not reported");

  property p_chan_c;
    @(posedge clock_i) disable iff (reset_i)
    (s_r.fsm == ST_STAMP && s_r.cfg.chan_c) |->
      ea_s[1:0] == 2'h0 && eb_s[1:0] == 2'h0 &&
      ed == EV_CW'((s_r.eb - s_r.ea) << CHAN_C_SHIFT);
  endproperty
  a_chan_c: assert property (p_chan_c)
    else $error("divided channel counts not scaled");

  property p_cfg;
    @(posedge clock_i) disable iff (reset_i)
    cfg_load_i |=> s_r.cfg == $past(cfg_i) && s_r.fsm == ST_GET_START;
  endproperty
  a_cfg: assert property (p_cfg)
    else $error("constants not loaded");

endmodule : interval_sample_postprocessor

// file: testbench/counter_source_model.sv
// Behavioural model of the counter hardware that feeds sample records.
// Assumes one clock shared with the post-processor; records are queued
// by the bench through push() and offered one at a time.
`timescale 1ns/100ps
module counter_source_model (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic slow_i,
  input wire logic sample_ready_i,
  output logic sample_valid_o,
  output postproc_pkg::sample_t sample_o,
  output int sent_o
);
  import postproc_pkg::*;

  // ----------------------------------------------------------------
  // Record queue
  // ----------------------------------------------------------------
  sample_t pend_q[$];
  sample_t rec;

  // Records keep the order given: start channel first, then stop
  task automatic push(input sample_t s);
    pend_q.push_back(s);
  endtask : push

  // ----------------------------------------------------------------
  // Offer loop
  // ----------------------------------------------------------------
  // Hold each record until ready is seen, then release the data lines
  initial begin
    sample_valid_o = 1'b0;
    sample_o = '0;
    sent_o = 0;
    forever begin
      @(posedge clock_i);
      if (!reset_i && pend_q.size() > 0) begin
        rec = pend_q.pop_front();
        sample_valid_o <= 1'b1;
        sample_o <= rec;
        do @(negedge clock_i); while (sample_ready_i !== 1'b1);
        @(posedge clock_i);
        sent_o <= sent_o + 1;
        sample_valid_o <= 1'b0;
        sample_o <= ~rec; // Released lines show no stale record
        if (slow_i) begin
          repeat (3) @(posedge clock_i);
        end
      end
    end
  end

endmodule : counter_source_model

// file: testbench/tb_interval_sample_postprocessor.sv
// Self-checking bench for the interval sample post-processor.
// Assumes counter_source_model feeds samples; the bench is the consumer.
`timescale 1ns/100ps
module tb_interval_sample_postprocessor;
  import postproc_pkg::*;

  // ----------------------------------------------------------------
  // Signals and constants
  // ----------------------------------------------------------------
  localparam longint WRAPL = 64'h0100_0000;
  localparam logic [CT_W-1:0] LIM = 32'h0080_0000;
  localparam longint TS = TIME_LSB_PS / INTERP_LSB_PS;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic cfg_load_i = 1'b0;
  cfg_t cfg_i = '0;
  logic sample_valid_i;
  sample_t sample_i;
  logic sample_ready_o;
  logic result_valid_o;
  result_t result_o;
  logic result_ready_i = 1'b0;
  logic slow = 1'b0;
  int sent;
  int mismatches = 0;
  int checks = 0;
  longint offs = 0;
  result_t res;

  // Clock of 4 ns period
  always #2 clock_i = ~clock_i;

  interval_sample_postprocessor i_interval_sample_postprocessor (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .cfg_load_i(cfg_load_i),
    .cfg_i(cfg_i),
    .sample_valid_i(sample_valid_i),
    .sample_i(sample_i),
    .sample_ready_o(sample_ready_o),
    .result_valid_o(result_valid_o),
    .result_o(result_o),
    .result_ready_i(result_ready_i)
  );

  counter_source_model i_counter_source_model (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .slow_i(slow),
    .sample_ready_i(sample_ready_o),
    .sample_valid_o(sample_valid_i),
    .sample_o(sample_i),
    .sent_o(sent)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [RES_W-1:0] seen,
                       input logic [RES_W-1:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  function automatic sample_t rec(input logic [TIME_W-1:0] t,
    input logic [INTERP_W-1:0] ip, input logic [EVENT_W-1:0] ev,
    input logic [1:0] fl);
    rec = '{block_start: fl[1], inhibit: fl[0], event_cnt: ev,
            time_cnt: t, interp: ip};
  endfunction : rec

  // Expected signed interval; adj is the rollover fix in counts
  function automatic longint ival(input sample_t a, input sample_t b,
                                  input longint adj);
    return (longint'(b.time_cnt) - longint'(a.time_cnt) + adj) * TS
      - longint'(b.interp) + longint'(a.interp) + offs;
  endfunction : ival

  task automatic load(input mode_t m, input logic ch, input longint off);
    offs = off;
    @(posedge clock_i);
    cfg_i <= '{time_wrap: CT_W'(WRAPL), pos_max: LIM, neg_max: LIM,
               event_wrap: EV_CW'(WRAPL), offset: STAMP_W'(off),
               mode: m, chan_c: ch};
    cfg_load_i <= 1'b1;
    @(posedge clock_i);
    cfg_load_i <= 1'b0;
  endtask : load

  task automatic pair(input sample_t a, input sample_t b);
    i_counter_source_model.push(a);
    i_counter_source_model.push(b);
  endtask : pair

  // Consumer side: raise ready, take one result, drop ready
  task automatic take(output result_t r);
    int n;
    n = 0;
    @(posedge clock_i);
    result_ready_i <= 1'b1;
    do begin
      @(negedge clock_i);
      n++;
    end while (result_valid_o !== 1'b1 && n < 400);
    if (n >= 400) begin
      mismatches++;
      $display("wrong value at %0t: no result", $time);
    end
    r = result_o;
    @(posedge clock_i);
    result_ready_i <= 1'b0;
  endtask : take

  task automatic expect_res(input longint v, input longint a);
    take(res);
    check(res.value, RES_W'(v));
    check(res.aux, RES_W'(a));
  endtask : expect_res

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_interval();
    sample_t a, b, c, d;
    a = rec(24'h000064, 6'h03, 24'h00000A, 2'b10);
    b = rec(24'h000096, 6'h05, 24'h00000C, 2'b01);
    c = rec(24'h0000C8, 6'h00, 24'h000014, 2'b00);
    d = rec(24'h0000B4, 6'h00, 24'h000019, 2'b00);
    load(MODE_INTERVAL, 1'b0, 64'h7);
    pair(a, b);
    pair(c, d);
    expect_res(ival(a, b, 0), 0);
    check(res.block_start, 1'b1);
    check(res.inhibit, 1'b1);
    expect_res(ival(c, d, 0), c.event_cnt - b.event_cnt - 1);
    $display("test interval done");
  endtask : test_interval

  task automatic test_wrap_in_pair();
    sample_t a, b, c, d;
    load(MODE_INTERVAL, 1'b0, 64'h0);
    a = rec(24'hFFFFF0, 6'h00, 24'h000001, 2'b00);
    b = rec(24'h000010, 6'h00, 24'h000002, 2'b00);
    c = rec(24'h000030, 6'h00, 24'h000003, 2'b00);
    d = rec(24'h000020, 6'h00, 24'h000004, 2'b00);
    pair(a, b);
    pair(c, d);
    expect_res(ival(a, b, WRAPL), 0);
    expect_res(ival(c, d, 0), 0);
    load(MODE_INTERVAL, 1'b0, 64'h0);
    pair(b, a);
    pair(rec(24'h000040, 6'h00, 24'h000003, 2'b00),
         rec(24'h000050, 6'h00, 24'h000004, 2'b00));
    expect_res(ival(b, a, -WRAPL), 0);
    expect_res(TS * 16, 1);
    $display("test wrap in pair done");
  endtask : test_wrap_in_pair

  task automatic test_between_pairs();
    load(MODE_INTERVAL, 1'b0, 64'h0);
    pair(rec(24'hFFFF00, 6'h00, 24'h000001, 2'b00),
         rec(24'hFFFF10, 6'h00, 24'h000002, 2'b00));
    pair(rec(24'h000020, 6'h00, 24'h000003, 2'b00),
         rec(24'h000010, 6'h00, 24'h000004, 2'b00));
    pair(rec(24'h000030, 6'h00, 24'h000005, 2'b00),
         rec(24'h000040, 6'h00, 24'h000006, 2'b00));
    expect_res(TS * 16, 0);
    expect_res(-TS * 16, 0);
    expect_res(TS * 16, 0);
    $display("test between pairs done");
  endtask : test_between_pairs

  task automatic test_rate();
    sample_t a, b;
    longint ev, gt;
    a = rec(24'h0003E8, 6'h00, 24'hFFFFF0, 2'b00);
    b = rec(24'h00044C, 6'h00, 24'h000010, 2'b00);
    ev = (longint'(b.event_cnt) + WRAPL - longint'(a.event_cnt)) * 4;
    load(MODE_RATE, 1'b1, 64'h0);
    gt = ival(a, b, 0);
    pair(a, b);
    expect_res((ev << FREQ_FRAC) / gt, gt);
    load(MODE_PERIOD, 1'b1, 64'h0);
    pair(a, b);
    expect_res(gt / ev, gt);
    load(MODE_RATE, 1'b0, 64'h64);
    gt = ival(a, b, 0);
    pair(a, b);
    expect_res(((ev / 4) << FREQ_FRAC) / gt, gt);
    $display("test rate done");
  endtask : test_rate

  task automatic test_backpressure();
    int k;
    int base;
    base = sent;
    load(MODE_INTERVAL, 1'b0, 64'h0);
    for (k = 0; k < 5; k++) begin
      pair(rec(TIME_W'(16 * k), 6'h00, EVENT_W'(10 * k), 2'b00),
           rec(TIME_W'(17 * k + 1), 6'h00, EVENT_W'(10 * k + 1), 2'b00));
    end
    repeat (40) @(posedge clock_i);
    @(negedge clock_i);
    check(sample_ready_o, 1'b0);
    check(RES_W'(sent - base), 64'h6);
    for (k = 0; k < 5; k++) begin
      take(res);
      check(res.value, RES_W'((k + 1) * TS));
    end
    repeat (4) @(posedge clock_i);
    @(negedge clock_i);
    check(sample_ready_o, 1'b1);
    $display("test backpressure done");
  endtask : test_backpressure

  task automatic test_div_zero();
    sample_t a, b;
    slow = 1'b1;
    a = rec(24'h000010, 6'h00, 24'h000005, 2'b00);
    b = rec(24'h000020, 6'h00, 24'h000005, 2'b00);
    load(MODE_PERIOD, 1'b0, 64'h0);
    pair(a, b);
    take(res);
    check(res.div_zero, 1'b1);
    check(res.value, {RES_W{1'b1}});
    load(MODE_RATE, 1'b0, 64'h0);
    pair(b, a);
    take(res);
    check(res.div_zero, 1'b1);
    check(res.value, {RES_W{1'b1}});
    $display("test divide by zero done");
  endtask : test_div_zero

  // ----------------------------------------------------------------
  // Verdict, main sequence and watchdog
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("checks %0d, mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  // Reset for 10 cycles, then run every scenario
  initial begin
    repeat (10) @(posedge clock_i);
    reset_i <= 1'b0;
    test_interval();
    test_wrap_in_pair();
    test_between_pairs();
    test_rate();
    test_backpressure();
    test_div_zero();
    print_verdict();
  end

  // Cuts a hang short at 50000 cycles, far beyond the few hundred cycles needed
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end

endmodule : tb_interval_sample_postprocessor
